// ### src/gate_drive_ctrl.sv
`timescale 1ns/1ns
module gate_drive_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pin-level inputs, asynchronous to clk_i
    input wire gate_drive_pkg::level_t pwm_level_i,
    input wire gate_drive_pkg::level_t skip_select_n_i,
    input wire gate_drive_pkg::sense_t sense_i,
    // Gate feedback, asynchronous: gate actually above threshold
    input wire logic high_gate_sensed_i,
    input wire logic low_gate_sensed_i,
    // Gate commands
    output gate_drive_pkg::gates_t gates_o,
    // Bias divider attach for the PWM pin
    output logic pwm_bias_en_o
);

    // ==========================================
    // Input synchronisers
    // ==========================================
    gate_drive_pkg::level_t pwm_s1_reg, pwm_reg;
    gate_drive_pkg::level_t skip_s1_reg, skip_reg, skip_prev_reg;
    gate_drive_pkg::sense_t sense_s1_reg, sense_reg;
    logic [1:0] fb_s1_reg, fb_reg;

    // Two flops on every asynchronous input
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwm_s1_reg <= gate_drive_pkg::LVL_LOW;
            pwm_reg <= gate_drive_pkg::LVL_LOW;
            skip_s1_reg <= gate_drive_pkg::LVL_HIGH;
            skip_reg <= gate_drive_pkg::LVL_HIGH;
            skip_prev_reg <= gate_drive_pkg::LVL_HIGH;
            sense_s1_reg <= '0;
            sense_reg <= '0;
            fb_s1_reg <= 2'h0;
            fb_reg <= 2'h0;
        end else begin
            pwm_s1_reg <= pwm_level_i;
            pwm_reg <= pwm_s1_reg;
            skip_s1_reg <= skip_select_n_i;
            skip_reg <= skip_s1_reg;
            skip_prev_reg <= skip_reg;
            sense_s1_reg <= sense_i;
            sense_reg <= sense_s1_reg;
            fb_s1_reg <= {high_gate_sensed_i, low_gate_sensed_i};
            fb_reg <= fb_s1_reg;
        end
    end

    // ==========================================
    // Decode
    // ==========================================
    logic enabled;
    logic skip_low;
    logic skip_fall;
    logic pwm_mid;
    logic high_sensed, low_sensed;

    // An open disable pin reads low through its pull-down, so it disables too
    assign enabled = sense_reg.drive_disable_n && !sense_reg.supply_lockout;
    // Mid and high skip share one decode; open pin arrives as high
    assign skip_low = (skip_reg == gate_drive_pkg::LVL_LOW);
    assign skip_fall = skip_low && (skip_prev_reg != gate_drive_pkg::LVL_LOW);
    assign pwm_mid = (pwm_reg == gate_drive_pkg::LVL_MID);
    assign high_sensed = fb_reg[1];
    assign low_sensed = fb_reg[0];
    assign pwm_bias_en_o = (skip_reg == gate_drive_pkg::LVL_MID);

    // ==========================================
    // Zero-current sequencing in mid level
    // ==========================================
    typedef enum logic [2:0] {
        ZC_IDLE,
        ZC_HOLD,
        ZC_WAIT,
        ZC_WATCH,
        ZC_DONE
    } zc_state_t;

    zc_state_t zc_reg;
    logic [gate_drive_pkg::TMR_W-1:0] hold_cnt_reg;
    logic [gate_drive_pkg::TMR_W-1:0] wait_cnt_reg;
    logic zc_early_reg;
    logic mid_zc_mode;
    logic low_on_reg;

    assign mid_zc_mode = enabled && pwm_mid && !skip_low;

    // Saturating timer step used by the hold, wait and non-overlap counters
    function automatic logic [gate_drive_pkg::TMR_W-1:0] tick(input logic [gate_drive_pkg::TMR_W-1:0] v);
        tick = (&v) ? v : v + 1'b1;
    endfunction

    // Wait timer runs from mid entry; the hold (blank plus debounce) starts once low gate is on
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            zc_reg <= ZC_IDLE;
            hold_cnt_reg <= '0;
            wait_cnt_reg <= '0;
            zc_early_reg <= 1'b0;
        end else if (!mid_zc_mode) begin
            zc_reg <= ZC_IDLE;
            hold_cnt_reg <= '0;
            wait_cnt_reg <= '0;
            zc_early_reg <= 1'b0;
        end else begin
            wait_cnt_reg <= tick(wait_cnt_reg);
            case (zc_reg)
                ZC_IDLE: begin
                    zc_reg <= ZC_HOLD;
                    hold_cnt_reg <= '0;
                end
                ZC_HOLD: begin
                    if (low_on_reg) begin
                        hold_cnt_reg <= tick(hold_cnt_reg);
                    end
                    // Low gate held on through blanking and debounce
                    if (hold_cnt_reg >= gate_drive_pkg::TMR_W'(gate_drive_pkg::BLANK_CYC
                            + gate_drive_pkg::DEBOUNCE_CYC)) begin
                        zc_reg <= ZC_WAIT;
                    end
                end
                ZC_WAIT: begin
                    // Detection before the wait expires is only remembered, not acted on
                    if (sense_reg.zero_current_detect) begin
                        zc_early_reg <= 1'b1;
                    end
                    if (wait_cnt_reg >= gate_drive_pkg::TMR_W'(gate_drive_pkg::WAIT_CYC)) begin
                        zc_reg <= zc_early_reg ? ZC_DONE : ZC_WATCH;
                    end
                end
                ZC_WATCH: begin
                    if (sense_reg.zero_current_detect) begin
                        zc_reg <= ZC_DONE;
                    end
                end
                default: begin
                    zc_reg <= ZC_DONE;
                end
            endcase
        end
    end

    // ==========================================
    // Skip falling edge latch
    // ==========================================
    logic skip_kill_reg;
    gate_drive_pkg::level_t pwm_prev_reg;

    // Last settled PWM level, so that only the second sync stage reads the first
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwm_prev_reg <= gate_drive_pkg::LVL_LOW;
        end else begin
            pwm_prev_reg <= pwm_reg;
        end
    end

    // A skip fall after low turn-on kills the low gate until PWM changes or the drive is disabled; a fall wins over a clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            skip_kill_reg <= 1'b0;
        end else if (skip_fall && low_on_reg && !gates_o.high_gate_cmd) begin
            skip_kill_reg <= 1'b1;
        end else if (pwm_reg != pwm_prev_reg || !enabled) begin
            skip_kill_reg <= 1'b0;
        end
    end

    // ==========================================
    // Wanted gate states
    // ==========================================
    logic want_high, want_low;

    always_comb begin
        want_high = 1'b0;
        want_low = 1'b0;
        if (enabled) begin
            case (pwm_reg)
                gate_drive_pkg::LVL_HIGH: begin
                    want_high = 1'b1;
                end
                gate_drive_pkg::LVL_MID: begin
                    // Skip low: both off; otherwise low on until zero current
                    want_low = !skip_low && (zc_reg != ZC_DONE);
                end
                default: begin
                    want_low = 1'b1;
                end
            endcase
            if (skip_kill_reg) begin
                want_low = 1'b0;
            end
        end
    end

    // ==========================================
    // Non-overlap and gate outputs
    // ==========================================
    logic [gate_drive_pkg::TMR_W-1:0] nol_cnt_reg;
    logic high_on_reg;

    // Turn-off is immediate; turn-on waits until the opposite gate is sensed off plus a delay
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            nol_cnt_reg <= '0;
        end else if ((want_high && !high_on_reg && !low_sensed && !low_on_reg)
                || (want_low && !low_on_reg && !high_sensed && !high_on_reg)) begin
            nol_cnt_reg <= tick(nol_cnt_reg);
        end else begin
            nol_cnt_reg <= '0;
        end
    end

    // High gate command
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            high_on_reg <= gate_drive_pkg::GATE_RESET;
        end else if (!want_high) begin
            high_on_reg <= 1'b0;
        end else if (!high_on_reg && nol_cnt_reg >= gate_drive_pkg::TMR_W'(gate_drive_pkg::NOL_CYC)) begin
            high_on_reg <= 1'b1;
        end
    end

    // Low gate command
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_on_reg <= gate_drive_pkg::GATE_RESET;
        end else if (!want_low) begin
            low_on_reg <= 1'b0;
        end else if (!low_on_reg && nol_cnt_reg >= gate_drive_pkg::TMR_W'(gate_drive_pkg::NOL_CYC)) begin
            low_on_reg <= 1'b1;
        end
    end

    assign gates_o.high_gate_cmd = high_on_reg;
    assign gates_o.low_gate_cmd = low_on_reg;

endmodule

// ### include/gate_drive_pkg.sv
package gate_drive_pkg;

    // ==========================================
    // Three-level input encodings
    // ==========================================
    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_MID,
        LVL_HIGH
    } level_t;

    // Comparator and supply status travelling together
    typedef struct packed {
        logic zero_current_detect;
        logic supply_lockout;
        logic drive_disable_n;
    } sense_t;

    // Gate command pair
    typedef struct packed {
        logic high_gate_cmd;
        logic low_gate_cmd;
    } gates_t;

    // ==========================================
    // Timing
    // ==========================================
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEBOUNCE_NS = 80;
    localparam int BLANK_NS = 200;
    localparam int WAIT_NS = 400;
    localparam int NOL_NS = 20;
    // Least times round up
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC = (WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOL_CYC = (NOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 10;

    // Reset values
    localparam logic GATE_RESET = 1'b0;

endpackage

// ### test/gate_drive_ctrl_asserts.sv
`timescale 1ns/1ns
// ==========================================
// Gate command checker
module gate_drive_ctrl_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Observed pins
    input wire gate_drive_pkg::level_t pwm_level_i,
    input wire gate_drive_pkg::level_t skip_select_n_i,
    input wire gate_drive_pkg::sense_t sense_i,
    input wire gate_drive_pkg::gates_t gates_o,
    input wire logic pwm_bias_en_o
);
    logic en;
    logic hi;
    logic lo;
    logic p_mid;
    logic s_low;
    logic s_mid;
    logic [9:0] mid_cnt_reg;
    // Short forms of the pin levels
    assign en = !sense_i.supply_lockout && sense_i.drive_disable_n;
    assign hi = gates_o.high_gate_cmd;
    assign lo = gates_o.low_gate_cmd;
    assign p_mid = pwm_level_i == gate_drive_pkg::LVL_MID;
    assign s_low = skip_select_n_i == gate_drive_pkg::LVL_LOW;
    assign s_mid = skip_select_n_i == gate_drive_pkg::LVL_MID;
    // Cycles in mid with skip high; saturates so a long stay never wraps
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !p_mid || skip_select_n_i != gate_drive_pkg::LVL_HIGH || !en) begin
            mid_cnt_reg <= 10'h000;
        end else if (mid_cnt_reg != 10'h3FF) begin
            mid_cnt_reg <= mid_cnt_reg + 10'h001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_no_overlap: assert property (!(hi && lo)) else $error("both gates commanded on");
    chk_disable_off: assert property ((!en)[*4] |-> gates_o == 2'h0) else $error("gate on while disabled");
    chk_skip_low_mid: assert property ((s_low && p_mid)[*4] |-> !lo) else $error("low gate on in mid");
    chk_high_lo_off: assert property ((pwm_level_i == gate_drive_pkg::LVL_HIGH)[*4] |-> !lo)
        else $error("low gate on with pwm high");
    chk_low_hi_off: assert property ((pwm_level_i == gate_drive_pkg::LVL_LOW)[*4] |-> !hi)
        else $error("high gate on with pwm low");
    chk_mid_hi_off: assert property (p_mid[*4] |-> !hi) else $error("high gate on with pwm mid");
    chk_bias_on: assert property (s_mid[*3] |-> pwm_bias_en_o) else $error("bias missing");
    chk_bias_off: assert property ((!s_mid)[*3] |-> !pwm_bias_en_o) else $error("bias stuck");
    chk_wait_first: assert property ($fell(lo) && mid_cnt_reg > 10'h003 |-> mid_cnt_reg >= gate_drive_pkg::WAIT_CYC)
        else $error("low gate off before wait");
    chk_zero_off: assert property ((mid_cnt_reg > gate_drive_pkg::WAIT_CYC + 10 && sense_i.zero_current_detect)[*5]
        |-> !lo) else $error("zero current ignored");
    chk_skip_fall: assert property (s_low && $past(skip_select_n_i) == gate_drive_pkg::LVL_HIGH && lo && !hi
        |-> ##[1:6] !lo) else $error("skip fall kept low gate");
endmodule

bind gate_drive_ctrl gate_drive_ctrl_asserts i_chk (.clk_i, .rst_n_i, .pwm_level_i, .skip_select_n_i, .sense_i,
    .gates_o, .pwm_bias_en_o);

// ### test/pwm_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================
// Controller model: presents the requested pin levels after a clock edge
module pwm_ctrl_model (
    // Clock
    input wire logic clk_i,
    // Requests from the bench
    input wire gate_drive_pkg::level_t pwm_req_i,
    input wire gate_drive_pkg::level_t skip_req_i,
    // Pins toward the driver
    output gate_drive_pkg::level_t pwm_level_o = gate_drive_pkg::LVL_LOW,
    output gate_drive_pkg::level_t skip_select_n_o = gate_drive_pkg::LVL_HIGH
);
    // High/low toggling for continuous mode, mid to enter discontinuous
    always @(posedge clk_i) begin
        pwm_level_o <= pwm_req_i;
    end
    // An open skip pin is presented high, as the pull-up makes it
    always @(posedge clk_i) begin
        skip_select_n_o <= skip_req_i;
    end
endmodule

// ### test/gate_drive_ctrl_tb.sv
`timescale 1ns/1ns
// ==========================================
// Gate drive bench
module gate_drive_ctrl_tb;
    logic clk_i;
    logic rst_n_i;
    gate_drive_pkg::level_t pwm_req;
    gate_drive_pkg::level_t skip_req;
    gate_drive_pkg::level_t pwm_level;
    gate_drive_pkg::level_t skip_select_n;
    gate_drive_pkg::sense_t sense;
    gate_drive_pkg::gates_t gates;
    logic bias;
    logic hs = 1'h0;
    logic ls = 1'h0;
    int fail_count = 0;
    int n_tests = 0;
    // Rows: pwm, skip, sense, expected {high, low, bias}
    logic [9:0] rows [10];
    pwm_ctrl_model i_ctrl (.clk_i(clk_i), .pwm_req_i(pwm_req), .skip_req_i(skip_req), .pwm_level_o(pwm_level),
        .skip_select_n_o(skip_select_n));
    gate_drive_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwm_level_i(pwm_level),
        .skip_select_n_i(skip_select_n), .sense_i(sense), .high_gate_sensed_i(hs), .low_gate_sensed_i(ls),
        .gates_o(gates), .pwm_bias_en_o(bias));
    // Gates sensed one cycle after command, so non-overlap waits are exercised
    always @(posedge clk_i) begin
        hs <= gates.high_gate_cmd;
        ls <= gates.low_gate_cmd;
    end
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Drive at an edge, then settle past the edge that ends the wait
    task automatic go(input logic [1:0] p, input logic [1:0] s, input logic [2:0] sn, input int n);
        @(posedge clk_i);
        pwm_req <= gate_drive_pkg::level_t'(p);
        skip_req <= gate_drive_pkg::level_t'(s);
        sense <= sn;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic give_verdict();
        $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Watchdog far beyond the roughly 950 cycles the tests need
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    initial begin
        rst_n_i = 1'h0;
        pwm_req = gate_drive_pkg::LVL_LOW;
        skip_req = gate_drive_pkg::LVL_HIGH;
        sense = 3'h1;
        rows = '{10'h28C, 10'h08A, 10'h20C, 10'h00A, 10'h108, 10'h24D, 10'h04B, 10'h14B, 10'h280, 10'h298};
        repeat (5) @(posedge clk_i);
        #1;
        check({gates, bias}, 3'h0);
        @(posedge clk_i);
        rst_n_i <= 1'h1;
        // Steady decode for every pin combination except pwm mid with skip high, and the disable cases
        foreach (rows[i]) begin
            go(rows[i][9:8], rows[i][7:6], rows[i][5:3], 30);
            check({gates, bias}, rows[i][2:0]);
        end
        // Early zero current: held until the wait ends, then off
        go(2'h0, 2'h2, 3'h1, 20);
        go(2'h1, 2'h2, 3'h5, 90);
        check({2'h0, gates.low_gate_cmd}, 3'h1);
        go(2'h1, 2'h2, 3'h5, 30);
        check({2'h0, gates.low_gate_cmd}, 3'h0);
        // Leaving mid and coming back restarts the wait
        go(2'h0, 2'h2, 3'h1, 10);
        go(2'h1, 2'h2, 3'h5, 60);
        go(2'h0, 2'h2, 3'h5, 10);
        go(2'h1, 2'h2, 3'h5, 90);
        check({2'h0, gates.low_gate_cmd}, 3'h1);
        // Late zero current turns the low gate off promptly
        go(2'h0, 2'h2, 3'h1, 10);
        go(2'h1, 2'h2, 3'h1, 150);
        check({2'h0, gates.low_gate_cmd}, 3'h1);
        go(2'h1, 2'h2, 3'h5, 8);
        check({2'h0, gates.low_gate_cmd}, 3'h0);
        // Skip fall with the low gate on kills it; a new pwm edge frees it
        go(2'h0, 2'h2, 3'h1, 20);
        go(2'h0, 2'h0, 3'h1, 10);
        check({2'h0, gates.low_gate_cmd}, 3'h0);
        go(2'h2, 2'h0, 3'h1, 10);
        go(2'h0, 2'h0, 3'h1, 20);
        check({2'h0, gates.low_gate_cmd}, 3'h1);
        // Skip fall while the high gate is on changes nothing
        go(2'h2, 2'h2, 3'h1, 20);
        go(2'h2, 2'h0, 3'h1, 10);
        check({1'h0, gates}, 3'h2);
        // Reset in mid-run drops the gates, and the block comes back on its own
        go(2'h0, 2'h2, 3'h1, 20);
        check({gates, bias}, 3'h2);
        @(posedge clk_i);
        rst_n_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        #1;
        check({gates, bias}, 3'h0);
        @(posedge clk_i);
        rst_n_i <= 1'h1;
        go(2'h0, 2'h2, 3'h1, 20);
        check({gates, bias}, 3'h2);
        give_verdict();
    end
endmodule
